// File: test/cfg_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// External pins: a driven pin shows the drive, an input shows the board.
module cfg_pin_model
(
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe_n,
	input wire logic [3:0] ext,
	output logic [3:0] pin_lvl
);
	assign pin_lvl = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
endmodule // cfg_pin_model
`default_nettype wire

// File: test/cfg_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_assertions #(
	parameter NCH = 8,
	parameter NPIN = 4
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [NPIN-1:0] pin_out,
	input wire logic [NPIN-1:0] pin_oe_n,
	input wire logic [NCH-1:0] channel_powerdown,
	input wire logic [NCH-1:0] frame_pos_alarm,
	input wire logic frame_strobe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire logic acc = psel & penable;
	wire logic wr = acc & pwrite & clk_en;
	wire logic wg = wr & (paddr == 12'h050);
	a_dir_reset: assert property ($past(sys_rst) |-> pin_oe_n == 4'hF)
		else $error("pins not inputs after reset");
	a_dir_write: assert property (wg |=> pin_oe_n == $past(pwdata[3:0]))
		else $error("direction bits not stored");
	a_out_write: assert property (wg |=> pin_out ==
		(($past(pwdata[7:4]) & ~pin_oe_n) | ($past(pin_out) & pin_oe_n)))
		else $error("pin drive level wrong");
	a_out_hold: assert property (!wg |=> $stable(pin_out))
		else $error("pin drive changed without write");
	a_pd_write: assert property (wr && paddr == 12'h014 |=>
		channel_powerdown[0] == $past(pwdata[7]))
		else $error("power-down bit not stored");
	a_pd_reset: assert property ($past(sys_rst) |-> channel_powerdown == '0)
		else $error("channel powered down after reset");
	a_ro_status: assert property (acc && paddr == 12'h048 |->
		!pslverr && prdata[31:8] == 24'h0)
		else $error("status read malformed");
	a_frame_hold: assert property (!frame_strobe |=> $stable(frame_pos_alarm))
		else $error("frame alarms moved without strobe");
	c_gpio: cover property (wg);
	c_unmapped: cover property (acc && pslverr);
	c_frame: cover property (frame_strobe ##1 frame_pos_alarm != '0);
endmodule // cfg_regs_assertions
bind cfg_regs cfg_regs_assertions #(.NCH(NCH), .NPIN(NPIN)) chk_i (
	.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pslverr(pslverr), .pin_out(pin_out),
	.pin_oe_n(pin_oe_n), .channel_powerdown(channel_powerdown),
	.frame_pos_alarm(frame_pos_alarm), .frame_strobe(frame_strobe));
`default_nettype wire

// File: test/channel_fault_gpio_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module channel_fault_gpio_regs_tb;
	logic mclk, sys_rst, psel, penable, pwrite, frame_strobe, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, q;
	logic [79:0] pos_level, neg_level;
	logic [3:0] ext, pin_lvl;
	logic [7:0] v;
	wire logic pready, pslverr, irq;
	wire logic [31:0] prdata;
	wire logic [3:0] pin_out, pin_oe_n;
	wire logic [7:0] pd, fpa, fna;
	wire logic [23:0] gain, sel;
	int num_errors = 0, samples_checked = 0, cyc = 0, k, c;
	logic [9:0] hi_t [8] = '{10'h3B6, 10'h39D, 10'h384, 10'h36B,
		10'h352, 10'h320, 10'h2EE, 10'h2BC};
	logic [2:0] gc [3] = '{3'h1, 3'h2, 3'h5};
	logic [2:0] mc [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
	cfg_regs uut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.pos_level(pos_level), .neg_level(neg_level), .pin_in(pin_lvl),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .channel_powerdown(pd),
		.channel_gain_code(gain), .channel_input_select(sel),
		.frame_pos_alarm(fpa), .frame_neg_alarm(fna),
		.frame_strobe(frame_strobe), .irq(irq));
	cfg_pin_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext),
		.pin_lvl(pin_lvl));
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic wrap_up();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("FAIL %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ix, logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, ix, 2'h0};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			num_errors++;
	endtask
	function automatic logic [79:0] lvl(int a, int b, logic [9:0] x, y);
		lvl = {8{10'h1F4}};
		lvl[a*10+:10] = x;
		lvl[b*10+:10] = y;
	endfunction
	initial
	begin
		void'($urandom(32'hFB3E));
		{sys_rst, psel, penable, pwrite, frame_strobe} = 5'h10;
		{paddr, pwdata, ext} = '0;
		pos_level = {8{10'h1F4}};
		neg_level = {8{10'h1F4}};
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		for (k = 0; k < 8; k++)
		begin
			apb(1'b0, 8'h05 + k, 0);
			chk("ch rst", 32'h10, q);
		end
		apb(1'b0, 8'h14, 0);
		chk("gpio rst", 32'h0F, q);
		for (k = 0; k < 8; k++)
		begin
			v = {1'($urandom), gc[k%3], 1'b0, mc[k%5]};
			apb(1'b1, 8'h05 + k, v);
			apb(1'b0, 8'h05 + k, 0);
			chk("ch", v, q);
			chk("pd", v[7], pd[k]);
			chk("gain", v[6:4], gain[k*3+:3]);
			chk("sel", v[2:0], sel[k*3+:3]);
		end
		for (k = 0; k < 8; k++)
		begin
			c = $urandom % 8;
			apb(1'b1, 8'h04, {k[2:0], 5'h0});
			pos_level <= lvl(c, (c + 1) % 8, hi_t[k] + 1, hi_t[k]);
			neg_level <= lvl(c, (c + 1) % 8, 10'h3E7 - hi_t[k], 10'h3E8 - hi_t[k]);
			// Status lags the comparator by one cycle; strobe after it settles.
			@(posedge mclk);
			frame_strobe <= 1'b1;
			@(posedge mclk);
			frame_strobe <= 1'b0;
			apb(1'b0, 8'h12, 0);
			chk("pos", 32'h1 << c, q);
			apb(1'b0, 8'h12, 0);
			chk("pos again", 32'h1 << c, q);
			apb(1'b0, 8'h13, 0);
			chk("neg", 32'h1 << c, q);
			chk("frame", 32'h1 << c, fpa);
		end
		pos_level <= {8{10'h1F4}};
		neg_level <= {8{10'h1F4}};
		apb(1'b1, 8'h20, 32'hFFFF);
		apb(1'b1, 8'h21, 32'h1 << c);
		pos_level <= lvl(c, c, 10'h3E8, 10'h3E8);
		apb(1'b0, 8'h20, 0);
		chk("irq stat", 32'h1 << c, q);
		chk("irq on", 1, irq);
		apb(1'b1, 8'h21, 0);
		@(posedge mclk);
		chk("irq masked", 0, irq);
		apb(1'b1, 8'h21, 32'h1 << c);
		apb(1'b1, 8'h20, 32'h1 << c);
		@(posedge mclk);
		chk("irq clear", 0, irq);
		ext <= 4'h8;
		apb(1'b1, 8'h14, 8'h5C);
		apb(1'b0, 8'h14, 0);
		chk("gpio rd", 32'h9C, q);
		chk("pin out", 4'h1, pin_out);
		chk("pin dir", 4'hC, pin_oe_n);
		v = $urandom;
		apb(1'b1, 8'h14, {v[3:0], 4'h0});
		apb(1'b0, 8'h14, 0);
		chk("gpio out", {v[3:0], 4'h0}, q);
		apb(1'b0, 8'h30, 0);
		chk("unmapped", 32'h0, q);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, 8'h13, 32'hFF);
		apb(1'b0, 8'h13, 0);
		chk("neg ro", 0, q);
		wrap_up();
	end
endmodule // channel_fault_gpio_regs_tb
`default_nettype wire

// File: verilog/cfg_fault_cmp.v
`timescale 1ns/1ps
`default_nettype none
`include "cfg_map.vh"

// Compares every input sample against the trip window, without latching.
module cfg_fault_cmp #(
	parameter NCH = 8
)
(
	input wire [NCH*`CFG_LVL_W-1:0] pos_level,
	input wire [NCH*`CFG_LVL_W-1:0] neg_level,
	input wire [`CFG_LVL_W-1:0] level_hi,
	input wire [`CFG_LVL_W-1:0] level_lo,
	output wire [NCH-1:0] pos_trip,
	output wire [NCH-1:0] neg_trip
);

	genvar i;
	generate
		for (i = 0; i < NCH; i = i + 1)
		begin : g_ch
			wire [`CFG_LVL_W-1:0] p;
			wire [`CFG_LVL_W-1:0] n;
			assign p = pos_level[i*`CFG_LVL_W +: `CFG_LVL_W];
			assign n = neg_level[i*`CFG_LVL_W +: `CFG_LVL_W];
			// RQ12 window compare
			assign pos_trip[i] = (p > level_hi) || (p < level_lo);
			assign neg_trip[i] = (n > level_hi) || (n < level_lo);
		end
	endgenerate

endmodule // cfg_fault_cmp

`default_nettype wire

// File: verilog/cfg_map.vh
`ifndef CFG_MAP_VH
`define CFG_MAP_VH

// Register indices (printed offsets are not all multiples of four).
`define CFG_IDX_CH1 8'h05
`define CFG_IDX_CH8 8'h0C
`define CFG_IDX_POS 8'h12
`define CFG_IDX_NEG 8'h13
`define CFG_IDX_GPIO 8'h14
`define CFG_IDX_TRIP 8'h04
`define CFG_IDX_IRQ_STAT 8'h20
`define CFG_IDX_IRQ_MASK 8'h21
// Channel settings fields.
`define CFG_PD_BIT 7
`define CFG_GAIN_HI 6
`define CFG_GAIN_LO 4
`define CFG_RSV_BIT 3
`define CFG_MUX_HI 2
`define CFG_MUX_LO 0
`define CFG_GAIN_X1 3'h1
`define CFG_GAIN_X2 3'h2
`define CFG_GAIN_X8 3'h5
`define CFG_MUX_NORMAL 3'h0
`define CFG_MUX_SHORT 3'h1
`define CFG_MUX_SUPPLY 3'h3
`define CFG_MUX_TEMP 3'h4
`define CFG_MUX_TEST 3'h5
// Reset values.
`define CFG_CH_RST 8'h10
`define CFG_DIR_RST 4'hF
`define CFG_TRIP_RST 3'h0
// Trip field position in the trip-level register.
`define CFG_TRIP_HI 7
`define CFG_TRIP_LO 5
// Trip levels in tenths of a percent of the supply span.
`define CFG_LVL_W 10
`define CFG_HI_0 10'h3B6
`define CFG_HI_1 10'h39D
`define CFG_HI_2 10'h384
`define CFG_HI_3 10'h36B
`define CFG_HI_4 10'h352
`define CFG_HI_5 10'h320
`define CFG_HI_6 10'h2EE
`define CFG_HI_7 10'h2BC
`define CFG_SPAN 10'h3E8

`endif

// File: verilog/cfg_regs.v
// Operation
// RQ1: Eight channel settings registers at consecutive indices, same layout.
// RQ2: Bit 7 powers the channel down when set; clear by default.
// RQ3: Gain field codes 001, 010, 101 give x1, x2, x8; others unusable.
// RQ4: Host writes zero to bit 3 of each channel settings register.
// RQ5: Input selector picks normal, shorted, supply, temperature or test input.
// RQ6: Positive-side alarm status, bit n-1 per channel, read-only, default 0.
// RQ7: Negative-side alarm status, same ordering, read-only, default 0.
// RQ8: Pin register has data in upper nibble, direction in lower nibble.
// RQ9: Reading pin data returns actual pin levels in either direction.
// RQ10: Data writes drive output pins and leave input pins unaffected.
// RQ11: Direction bit zero means output, one means input; reset all inputs.
// RQ12: Inputs compare against high and low levels from a 3-bit trip code.
// RQ13: Code 000 trips at 95 percent high and 5 percent low.
// RQ14: Alarm status bits also go out with each output data frame.
// RQ15: Codes map to 95 down to 70 percent high, 5 to 30 low.
// RQ16: Status follows comparators live; reading it has no side effect.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_map.vh"

module cfg_regs #(
	parameter NCH = 8,
	parameter NPIN = 4
)
(
	input wire mclk,
	input wire sys_rst,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire [NCH*`CFG_LVL_W-1:0] pos_level,
	input wire [NCH*`CFG_LVL_W-1:0] neg_level,
	input wire [NPIN-1:0] pin_in,
	output wire [NPIN-1:0] pin_out,
	output wire [NPIN-1:0] pin_oe_n,
	output wire [NCH-1:0] channel_powerdown,
	output wire [NCH*3-1:0] channel_gain_code,
	output wire [NCH*3-1:0] channel_input_select,
	output reg [NCH-1:0] frame_pos_alarm,
	output reg [NCH-1:0] frame_neg_alarm,
	input wire frame_strobe,
	output wire irq
);

	reg [7:0] chset_r [0:NCH-1];
	reg [2:0] trip_level_code_r;
	reg [NPIN-1:0] pin_level_bits_r;
	reg [NPIN-1:0] pin_direction_bits_r;
	reg [NPIN-1:0] pin_sync_r;
	reg [NCH-1:0] pos_input_alarm_status_r;
	reg [NCH-1:0] neg_input_alarm_status_r;
	reg [2*NCH-1:0] irq_stat_r;
	reg [2*NCH-1:0] irq_mask_r;
	reg [2*NCH-1:0] irq_stat_nxt;
	wire [`CFG_LVL_W-1:0] level_hi;
	wire [`CFG_LVL_W-1:0] level_lo;
	wire [NCH-1:0] pos_trip;
	wire [NCH-1:0] neg_trip;
	wire [2*NCH-1:0] rise;
	wire [9:0] idx;
	wire acc;
	wire wr;
	wire rd_ok;
	integer k;

	// Register index of a byte address; the low two bits select nothing.
	function [9:0] word_idx;
		input [11:0] a;
		begin
			word_idx = a[11:2];
		end
	endfunction

	// Channel number of a settings index, valid only inside the range.
	function [2:0] ch_of;
		input [9:0] i;
		reg [9:0] d;
		begin
			d = i - {2'h0, `CFG_IDX_CH1};
			ch_of = d[2:0];
		end
	endfunction

	function is_ch;
		input [9:0] i;
		begin
			is_ch = (i >= {2'h0, `CFG_IDX_CH1}) &&
				(i <= {2'h0, `CFG_IDX_CH8});
		end
	endfunction

	assign idx = word_idx(paddr);
	assign acc = psel && penable;
	assign wr = acc && pwrite && clk_en;
	assign pready = 1'b1;
	assign rd_ok = is_ch(idx) || idx == {2'h0, `CFG_IDX_TRIP} ||
		idx == {2'h0, `CFG_IDX_POS} || idx == {2'h0, `CFG_IDX_NEG} ||
		idx == {2'h0, `CFG_IDX_GPIO} ||
		idx == {2'h0, `CFG_IDX_IRQ_STAT} ||
		idx == {2'h0, `CFG_IDX_IRQ_MASK};
	assign pslverr = acc && !rd_ok;

	cfg_trip_dac u_dac (
		.code(trip_level_code_r),
		.level_hi(level_hi),
		.level_lo(level_lo)
	);

	cfg_fault_cmp #(.NCH(NCH)) u_cmp (
		.pos_level(pos_level),
		.neg_level(neg_level),
		.level_hi(level_hi),
		.level_lo(level_lo),
		.pos_trip(pos_trip),
		.neg_trip(neg_trip)
	);

	// Settings and control registers.
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			for (k = 0; k < NCH; k = k + 1)
				chset_r[k] <= `CFG_CH_RST;
			trip_level_code_r <= `CFG_TRIP_RST;
			pin_level_bits_r <= {NPIN{1'b0}};
			// RQ11 reset to inputs
			pin_direction_bits_r <= `CFG_DIR_RST;
			irq_mask_r <= {2*NCH{1'b0}};
		end
		else if (wr)
		begin
			// RQ1 consecutive channel registers
			if (is_ch(idx))
			begin
				// RQ4 reserved bit forced
				chset_r[ch_of(idx)] <= pwdata[7:0] &
					~(8'h01 << `CFG_RSV_BIT);
			end
			if (idx == {2'h0, `CFG_IDX_TRIP})
				trip_level_code_r <=
					pwdata[`CFG_TRIP_HI:`CFG_TRIP_LO];
			if (idx == {2'h0, `CFG_IDX_GPIO})
			begin
				// RQ8 nibble layout
				pin_direction_bits_r <= pwdata[NPIN-1:0];
				// RQ10 output pins only
				for (k = 0; k < NPIN; k = k + 1)
					if (!pwdata[k])
						pin_level_bits_r[k] <= pwdata[NPIN+k];
			end
			if (idx == {2'h0, `CFG_IDX_IRQ_MASK})
				irq_mask_r <= pwdata[2*NCH-1:0];
		end
	end

	// Pin levels and alarm status follow their sources on every cycle with clk_en high.
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pin_sync_r <= {NPIN{1'b0}};
			pos_input_alarm_status_r <= {NCH{1'b0}};
			neg_input_alarm_status_r <= {NCH{1'b0}};
			frame_pos_alarm <= {NCH{1'b0}};
			frame_neg_alarm <= {NCH{1'b0}};
			irq_stat_r <= {2*NCH{1'b0}};
		end
		else if (clk_en)
		begin
			// RQ9 actual pin level
			pin_sync_r <= pin_in;
			// RQ16 live, unlatched
			pos_input_alarm_status_r <= pos_trip;
			neg_input_alarm_status_r <= neg_trip;
			// RQ14 frame copy
			if (frame_strobe)
			begin
				frame_pos_alarm <= pos_input_alarm_status_r;
				frame_neg_alarm <= neg_input_alarm_status_r;
			end
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// Rising alarms set sticky bits; a set beats a same-cycle clear.
	assign rise = {neg_trip & ~neg_input_alarm_status_r,
		pos_trip & ~pos_input_alarm_status_r};

	always @*
	begin
		irq_stat_nxt = irq_stat_r;
		if (wr && idx == {2'h0, `CFG_IDX_IRQ_STAT})
			irq_stat_nxt = irq_stat_nxt & ~pwdata[2*NCH-1:0];
		irq_stat_nxt = irq_stat_nxt | rise;
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// RQ11 zero drives pin
	assign pin_oe_n = pin_direction_bits_r;
	assign pin_out = pin_level_bits_r;

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1)
		begin : g_out
			// RQ2 powerdown bit
			assign channel_powerdown[g] = chset_r[g][`CFG_PD_BIT];
			// RQ3 gain field
			assign channel_gain_code[g*3 +: 3] =
				chset_r[g][`CFG_GAIN_HI:`CFG_GAIN_LO];
			// RQ5 input selector
			assign channel_input_select[g*3 +: 3] =
				chset_r[g][`CFG_MUX_HI:`CFG_MUX_LO];
		end
	endgenerate

	// Read mux; status reads have no side effect.
	always @*
	begin
		prdata = 32'h0000_0000;
		if (is_ch(idx))
			prdata[7:0] = chset_r[ch_of(idx)];
		else if (idx == {2'h0, `CFG_IDX_TRIP})
			prdata[`CFG_TRIP_HI:`CFG_TRIP_LO] = trip_level_code_r;
		// RQ6 positive status
		else if (idx == {2'h0, `CFG_IDX_POS})
			prdata[NCH-1:0] = pos_input_alarm_status_r;
		// RQ7 negative status
		else if (idx == {2'h0, `CFG_IDX_NEG})
			prdata[NCH-1:0] = neg_input_alarm_status_r;
		// RQ9 pin readback
		else if (idx == {2'h0, `CFG_IDX_GPIO})
			prdata[2*NPIN-1:0] = {pin_sync_r, pin_direction_bits_r};
		else if (idx == {2'h0, `CFG_IDX_IRQ_STAT})
			prdata[2*NCH-1:0] = irq_stat_r;
		else if (idx == {2'h0, `CFG_IDX_IRQ_MASK})
			prdata[2*NCH-1:0] = irq_mask_r;
	end

endmodule // cfg_regs

`default_nettype wire

// File: verilog/cfg_trip_dac.v
`timescale 1ns/1ps
`default_nettype none
`include "cfg_map.vh"

// Maps the trip code to high and low trip levels (tenths of a percent).
module cfg_trip_dac
(
	input wire [2:0] code,
	output reg [`CFG_LVL_W-1:0] level_hi,
	output wire [`CFG_LVL_W-1:0] level_lo
);

	// RQ15 level table
	always @*
	begin
		case (code)
			3'h0: level_hi = `CFG_HI_0;
			3'h1: level_hi = `CFG_HI_1;
			3'h2: level_hi = `CFG_HI_2;
			3'h3: level_hi = `CFG_HI_3;
			3'h4: level_hi = `CFG_HI_4;
			3'h5: level_hi = `CFG_HI_5;
			3'h6: level_hi = `CFG_HI_6;
			default: level_hi = `CFG_HI_7;
		endcase
	end

	// RQ13 symmetric low level
	assign level_lo = `CFG_SPAN - level_hi;

endmodule // cfg_trip_dac

`default_nettype wire
